// File: iglc_pkg.sv
// constants and slot descriptor layout for the issue group legality checker
// assumes the dispatch stage pre-decodes every slot of a group into iglc_slot_type
package iglc_pkg;

  // group limits
  localparam logic [3:0] EXT_BUDGET = 4'h2;
  localparam logic [1:0] EXT_TWO = 2'h2;
  localparam logic [1:0] EXT_ONE = 2'h1;
  localparam logic [3:0] MAX_TWO_WORD = 4'h2;
  localparam logic [3:0] MAX_SG_AGU = 4'h1;
  localparam logic [3:0] MAX_SG_DATA_ARITH_UNIT = 4'h2;
  localparam logic [3:0] MAX_SUBGROUPS = 4'h2;
  localparam logic [3:0] MAX_SWW = 4'h1;

  // spacing, in core clock cycles, and the low-bank pointer bound
  localparam logic [1:0] MOD_CTL_GAP_CYC = 2'h2;
  localparam logic [1:0] MOD_CTL_AGE_RST = 2'h2;
  localparam logic [3:0] LOW_BANK_PTRS = 4'h8;

  // address register ids: 0..15 pointers, 16..19 offset registers
  localparam int NUM_AREGS = 20;
  localparam int ID_W = 5;

  // subgroup codes
  localparam logic [1:0] SG_NONE = 2'h0;
  localparam logic [1:0] SG_COND_A = 2'h1;
  localparam logic [1:0] SG_COND_B = 2'h2;
  localparam logic [1:0] SG_ALWAYS = 2'h3;

  // exclusive class bits
  localparam int CLS_MARK = 0;
  localparam int CLS_DEBUG = 1;
  localparam int CLS_INTR = 2;
  localparam int CLS_LOOP = 3;
  localparam int NUM_CLS = 4;

  // violation category bits
  localparam int V_EXT = 0;
  localparam int V_EXCL = 1;
  localparam int V_SWW = 2;
  localparam int V_XRET = 3;
  localparam int V_NMSRC = 4;
  localparam int V_SGLIM = 5;
  localparam int V_SHAPE = 6;
  localparam int V_ACC_D = 7;
  localparam int V_ACC_SG = 8;
  localparam int V_MODCTL = 9;
  localparam int V_ASPACE = 10;
  localparam int V_AWR_RD = 11;
  localparam int V_LPC = 12;
  localparam int V_EMR = 13;
  localparam int NUM_VIOL = 14;

  typedef struct packed {
    logic valid;
    logic [1:0] sg;
    logic cond_prefix;
    logic is_prefix;
    logic [1:0] ext;
    logic [NUM_CLS-1:0] cls;
    logic sww;
    logic xret;
    logic stk_ret;
    logic address_unit;
    logic agu_impl;
    logic agu_dreg;
    logic data_arith_unit;
    logic acc;
    logic acc_alu;
    logic nm_src_v;
    logic [ID_W-1:0] nm_src;
    logic emr_rd;
    logic lpc_wr_v;
    logic [1:0] lpc_wr;
    logic lpc_rd_v;
    logic [1:0] lpc_rd;
    logic awr_v;
    logic [ID_W-1:0] awr;
    logic mrd_v;
    logic [ID_W-1:0] mrd;
    logic mod_ctl_wr;
    logic ptr_v;
    logic [3:0] ptr;
    logic ptr_noupd;
    logic mwr_v;
    logic [ID_W-1:0] mwr;
    logic ause_v;
    logic [ID_W-1:0] ause;
  } iglc_slot_type;

  localparam int SLOT_W = $bits(iglc_slot_type);

endpackage

// File: iglc_spacing_if.sv
// spacing notifications between group checker and spacing tracker
// assumes both ends run on the core clock
`timescale 1ns/1ps
`default_nettype none
interface iglc_spacing_if;
  logic grp_valid;
  logic mod_ctl_wr;
  logic low_mod_use;
  logic [iglc_pkg::NUM_AREGS-1:0] wr_mask;
  logic [iglc_pkg::NUM_AREGS-1:0] use_mask;
  logic mod_ctl_hazard;
  logic addr_hazard;

  modport chk_side (
    output grp_valid, mod_ctl_wr, low_mod_use, wr_mask, use_mask,
    input mod_ctl_hazard, addr_hazard
  );
  modport trk_side (
    input grp_valid, mod_ctl_wr, low_mod_use, wr_mask, use_mask,
    output mod_ctl_hazard, addr_hazard
  );
endinterface
`default_nettype wire

// File: iglc_spacing_tracker.sv
// cross-group spacing tracker: modifier-control age and last-cycle address writes
// assumes one group per valid cycle; idle cycles still count as elapsed cycles
`timescale 1ns/1ps
`default_nettype none
module iglc_spacing_tracker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // spacing link
  iglc_spacing_if.trk_side sp
);

  typedef struct packed {
    logic [1:0] mod_age;
    logic [iglc_pkg::NUM_AREGS-1:0] prev_wr;
  } iglc_trk_state_type;

  iglc_trk_state_type st_reg;
  iglc_trk_state_type st_next;

  always_comb begin
    st_next = st_reg;
    // saturate so an old write never wraps back into a hazard
    if (st_reg.mod_age < iglc_pkg::MOD_CTL_GAP_CYC) begin
      st_next.mod_age = st_reg.mod_age + 2'h1;
    end
    if (sp.grp_valid && sp.mod_ctl_wr) begin
      st_next.mod_age = 2'h0;
    end
    // one cycle of history is all the address spacing needs
    st_next.prev_wr = sp.grp_valid ? sp.wr_mask : '0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg.mod_age <= iglc_pkg::MOD_CTL_AGE_RST;
      st_reg.prev_wr <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sp.mod_ctl_hazard = sp.grp_valid && sp.low_mod_use &&
    (st_reg.mod_age < iglc_pkg::MOD_CTL_GAP_CYC);
  assign sp.addr_hazard = sp.grp_valid && (|(st_reg.prev_wr & sp.use_mask));

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  mod_gap_one_a: assert property (
    (sp.grp_valid && sp.mod_ctl_wr) ##1 (sp.grp_valid && sp.low_mod_use) |-> sp.mod_ctl_hazard)
    else $error("low pointer use right after modifier write not flagged");
  mod_gap_two_a: assert property (
    (sp.grp_valid && sp.mod_ctl_wr) ##1 1'b1 ##1 (sp.grp_valid && sp.low_mod_use)
    |-> sp.mod_ctl_hazard)
    else $error("low pointer use two cycles after modifier write not flagged");
  mod_gap_clear_a: assert property (
    (sp.grp_valid && sp.mod_ctl_wr) ##1 (!(sp.grp_valid && sp.mod_ctl_wr))[*3]
    |-> !sp.mod_ctl_hazard)
    else $error("modifier spacing hazard lasts too long");
  addr_gap_a: assert property (
    !$past(sp.grp_valid) |-> !sp.addr_hazard)
    else $error("address spacing hazard without a preceding group");
  addr_gap_hit_a: assert property (
    // reset wipes the history, so a write on a reset edge is not carried
    !$past(i_rst) && $past(sp.grp_valid) && sp.grp_valid &&
    (|($past(sp.wr_mask) & sp.use_mask)) |-> sp.addr_hazard)
    else $error("address use right after data write not flagged");

  mod_hazard_c: cover property (sp.mod_ctl_hazard);
  addr_hazard_c: cover property (sp.addr_hazard);

endmodule
`default_nettype wire

// File: iglc_checker.sv
// issue group legality checker: grouping limits and cross-group spacing
// assumes dispatch presents a whole pre-decoded group in one cycle on i_grp_valid
// Overview of operation
// - at most two extension words per group
// - three-word instruction only with single-word ones
// - at most two two-word instructions per group
// - second and third words count as extension
// - one instruction per exclusive class per subgroup
// - stop, wait, change-of-flow never grouped together
// - exception return alone among address-unit, one subgroup
// - offset or modulo data source once per subgroup
// - two subgroups: one address, two arithmetic each
// - prefixes uncounted, implicit address operations counted
// - at most two subgroups, none empty
// - unconditional-execute subgroup must come last
// - no data-register address op with accelerator
// - accelerator arithmetic all in one subgroup
// - two cycles from modifier write to low-pointer use
// - high pointers and no-update mode exempt
// - one cycle from data write to address use
// - base/modulo writes exempt, base alias not
// - address write not grouped with data read
// - loop counter write not grouped with read
// - stack return not grouped with mode read
`timescale 1ns/1ps
`default_nettype none
module iglc_checker #(
  parameter int SLOTS = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // group from dispatch
  input wire logic i_grp_valid,
  input wire logic [SLOTS*iglc_pkg::SLOT_W-1:0] i_grp_slots,
  // verdict, one cycle after the group
  output logic o_chk_valid,
  output logic o_illegal,
  output logic [iglc_pkg::NUM_VIOL-1:0] o_viol
);

  typedef struct packed {
    logic chk_valid;
    logic illegal;
    logic [iglc_pkg::NUM_VIOL-1:0] viol;
  } iglc_chk_state_type;

  iglc_chk_state_type st_reg;
  iglc_chk_state_type st_next;
  iglc_pkg::iglc_slot_type slot [SLOTS];
  iglc_spacing_if sp ();

  // helpers; ext_total, has_three, sww_cnt, n_sg, order_bad and sg_over also watched by the properties below
  logic [3:0] ext_total;
  logic [3:0] two_word_cnt;
  logic [3:0] ext_slots;
  logic [3:0] sww_cnt;
  logic [3:0] n_sg;
  logic has_three;
  logic sg_over;
  logic order_bad;
  logic empty_sg;
  logic pair_excl;

  for (genvar g = 0; g < SLOTS; g++) begin : g_unpack
    assign slot[g] = i_grp_slots[g*iglc_pkg::SLOT_W +: iglc_pkg::SLOT_W];
  end

  iglc_spacing_tracker u_trk (
    .i_ref_clk (i_ref_clk),
    .i_rst (i_rst),
    .sp (sp)
  );

  // false only for one slot in each of the two differing-condition subgroups
  function automatic logic co_exec(input iglc_pkg::iglc_slot_type a,
                                   input iglc_pkg::iglc_slot_type b);
    co_exec = !((a.sg == iglc_pkg::SG_COND_A && b.sg == iglc_pkg::SG_COND_B) ||
                (a.sg == iglc_pkg::SG_COND_B && b.sg == iglc_pkg::SG_COND_A));
  endfunction

  // a slot that takes an execution unit
  function automatic logic counted(input iglc_pkg::iglc_slot_type s);
    counted = s.valid && !s.is_prefix;
  endfunction

  function automatic logic any_agu(input iglc_pkg::iglc_slot_type s);
    any_agu = s.valid && (s.address_unit || s.agu_impl);
  endfunction

  logic [3:0] agu_cnt [4];
  logic [3:0] data_arith_unit_cnt [4];
  logic [3:0] sg_open;
  logic [3:0] sg_used;
  logic [iglc_pkg::NUM_VIOL-1:0] v;
  logic seen_always;
  logic xret_seen;
  logic acc_seen;
  logic agu_dreg_seen;
  logic acc_alu_seen;
  logic [1:0] acc_sg;

  // spacing notices in a process of their own: the verdict logic only reads the hazards back,
  // so no process both drives the tracker and listens to it
  always_comb begin
    sp.grp_valid = i_grp_valid;
    sp.mod_ctl_wr = 1'b0;
    sp.low_mod_use = 1'b0;
    sp.wr_mask = '0;
    sp.use_mask = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (slot[i].valid) begin
        if (slot[i].mod_ctl_wr) begin
          sp.mod_ctl_wr = 1'b1;
        end
        // high bank and no-update accesses do not see the modifier
        if (slot[i].ptr_v && !slot[i].ptr_noupd && slot[i].ptr < iglc_pkg::LOW_BANK_PTRS) begin
          sp.low_mod_use = 1'b1;
        end
        // base alias writes arrive as pointer ids 8..15; base/modulo writes never appear
        for (int k = 0; k < iglc_pkg::NUM_AREGS; k++) begin
          if (slot[i].mwr_v && slot[i].mwr == iglc_pkg::ID_W'(k)) begin
            sp.wr_mask[k] = 1'b1;
          end
          if (slot[i].ause_v && slot[i].ause == iglc_pkg::ID_W'(k)) begin
            sp.use_mask[k] = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    ext_total = '0;
    two_word_cnt = '0;
    ext_slots = '0;
    sww_cnt = '0;
    n_sg = '0;
    has_three = 1'b0;
    sg_over = 1'b0;
    order_bad = 1'b0;
    empty_sg = 1'b0;
    pair_excl = 1'b0;
    sg_open = '0;
    sg_used = '0;
    v = '0;
    seen_always = 1'b0;
    xret_seen = 1'b0;
    acc_seen = 1'b0;
    agu_dreg_seen = 1'b0;
    acc_alu_seen = 1'b0;
    acc_sg = iglc_pkg::SG_NONE;
    for (int k = 0; k < 4; k++) begin
      agu_cnt[k] = '0;
      data_arith_unit_cnt[k] = '0;
    end

    // per-slot scan
    for (int i = 0; i < SLOTS; i++) begin
      if (slot[i].valid) begin
        ext_total = ext_total + {2'h0, slot[i].ext};
        if (slot[i].ext == iglc_pkg::EXT_TWO) begin
          has_three = 1'b1;
        end
        if (slot[i].ext == iglc_pkg::EXT_ONE) begin
          two_word_cnt = two_word_cnt + 4'h1;
        end
        if (slot[i].ext != 2'h0) begin
          ext_slots = ext_slots + 4'h1;
        end
        sww_cnt = sww_cnt + {3'h0, slot[i].sww};
        if (slot[i].cond_prefix) begin
          sg_open[slot[i].sg] = 1'b1;
        end
        // prefixes take no unit; implicit address ops do
        if (counted(slot[i])) begin
          sg_used[slot[i].sg] = 1'b1;
          if (slot[i].address_unit || slot[i].agu_impl) begin
            agu_cnt[slot[i].sg] = agu_cnt[slot[i].sg] + 4'h1;
          end
          if (slot[i].data_arith_unit) begin
            data_arith_unit_cnt[slot[i].sg] = data_arith_unit_cnt[slot[i].sg] + 4'h1;
          end
        end
        if (seen_always && slot[i].sg != iglc_pkg::SG_ALWAYS) begin
          order_bad = 1'b1;
        end
        if (slot[i].sg == iglc_pkg::SG_ALWAYS) begin
          seen_always = 1'b1;
        end
        if (slot[i].xret) begin
          xret_seen = 1'b1;
        end
        if (slot[i].acc) begin
          acc_seen = 1'b1;
        end
        // only explicit address ops; implicit transfers are generated for the accelerator
        if (slot[i].address_unit && slot[i].agu_dreg) begin
          agu_dreg_seen = 1'b1;
        end
        if (slot[i].acc_alu) begin
          if (acc_alu_seen && slot[i].sg != acc_sg) begin
            v[iglc_pkg::V_ACC_SG] = 1'b1;
          end
          acc_alu_seen = 1'b1;
          acc_sg = slot[i].sg;
        end
      end
    end

    // pairwise scan
    for (int i = 0; i < SLOTS; i++) begin
      for (int j = 0; j < SLOTS; j++) begin
        if (i != j && slot[i].valid && slot[j].valid) begin
          if (slot[i].xret && any_agu(slot[j])) begin
            v[iglc_pkg::V_XRET] = 1'b1;
          end
          if (co_exec(slot[i], slot[j])) begin
            if (i < j && (|(slot[i].cls & slot[j].cls))) begin
              pair_excl = 1'b1;
            end
            if (i < j && slot[i].nm_src_v && slot[j].nm_src_v &&
                slot[i].nm_src == slot[j].nm_src) begin
              v[iglc_pkg::V_NMSRC] = 1'b1;
            end
            if (slot[i].awr_v && slot[j].mrd_v && slot[i].awr == slot[j].mrd) begin
              v[iglc_pkg::V_AWR_RD] = 1'b1;
            end
            if (slot[i].lpc_wr_v && slot[j].lpc_rd_v && slot[i].lpc_wr == slot[j].lpc_rd) begin
              v[iglc_pkg::V_LPC] = 1'b1;
            end
            if (slot[i].stk_ret && slot[j].emr_rd) begin
              v[iglc_pkg::V_EMR] = 1'b1;
            end
          end
        end
      end
    end

    // group-level verdicts
    for (int k = 1; k < 4; k++) begin
      if (sg_open[k] || sg_used[k]) begin
        n_sg = n_sg + 4'h1;
      end
      if (sg_open[k] && !sg_used[k]) begin
        empty_sg = 1'b1;
      end
    end
    if (n_sg >= iglc_pkg::MAX_SUBGROUPS) begin
      for (int k = 1; k < 4; k++) begin
        if (agu_cnt[k] > iglc_pkg::MAX_SG_AGU || data_arith_unit_cnt[k] > iglc_pkg::MAX_SG_DATA_ARITH_UNIT) begin
          sg_over = 1'b1;
        end
      end
    end
    if (ext_total > iglc_pkg::EXT_BUDGET) begin
      v[iglc_pkg::V_EXT] = 1'b1;
    end
    if (has_three && ext_slots > 4'h1) begin
      v[iglc_pkg::V_EXT] = 1'b1;
    end
    if (two_word_cnt > iglc_pkg::MAX_TWO_WORD) begin
      v[iglc_pkg::V_EXT] = 1'b1;
    end
    v[iglc_pkg::V_EXCL] = pair_excl;
    if (sww_cnt > iglc_pkg::MAX_SWW) begin
      v[iglc_pkg::V_SWW] = 1'b1;
    end
    if (xret_seen && n_sg >= iglc_pkg::MAX_SUBGROUPS) begin
      v[iglc_pkg::V_XRET] = 1'b1;
    end
    v[iglc_pkg::V_SGLIM] = sg_over;
    if (n_sg > iglc_pkg::MAX_SUBGROUPS || empty_sg || order_bad) begin
      v[iglc_pkg::V_SHAPE] = 1'b1;
    end
    if (agu_dreg_seen && acc_seen) begin
      v[iglc_pkg::V_ACC_D] = 1'b1;
    end
    v[iglc_pkg::V_MODCTL] = sp.mod_ctl_hazard;
    v[iglc_pkg::V_ASPACE] = sp.addr_hazard;

    // verdict only for cycles carrying a group
    st_next.chk_valid = i_grp_valid;
    st_next.viol = i_grp_valid ? v : '0;
    st_next.illegal = i_grp_valid && (|v);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_chk_valid = st_reg.chk_valid;
  assign o_illegal = st_reg.illegal;
  assign o_viol = st_reg.viol;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  illegal_summary_a: assert property (o_illegal == (|o_viol))
    else $error("illegal flag disagrees with category bits");
  idle_quiet_a: assert property (!$past(i_grp_valid) |-> !o_chk_valid && o_viol == '0)
    else $error("verdict without a group");
  ext_budget_a: assert property (
    // a group on a reset edge is dropped, so its verdict is not owed
    !$past(i_rst) && $past(i_grp_valid) && $past(ext_total) > iglc_pkg::EXT_BUDGET
    |-> o_viol[iglc_pkg::V_EXT])
    else $error("extension budget overrun not flagged");
  ext_clean_a: assert property (
    $past(i_grp_valid) && $past(ext_total) <= iglc_pkg::EXT_BUDGET && !$past(has_three)
    |-> !o_viol[iglc_pkg::V_EXT])
    else $error("extension flag without cause");
  sww_pair_a: assert property (
    !$past(i_rst) && $past(i_grp_valid)
    |-> o_viol[iglc_pkg::V_SWW] == ($past(sww_cnt) > iglc_pkg::MAX_SWW))
    else $error("stop/wait/flow grouping verdict wrong");
  sg_limit_a: assert property (
    $past(i_grp_valid) && $past(n_sg) < iglc_pkg::MAX_SUBGROUPS |-> !o_viol[iglc_pkg::V_SGLIM])
    else $error("subgroup limit applied to a single-condition group");
  sg_order_a: assert property (
    !$past(i_rst) && $past(i_grp_valid) && $past(order_bad)
    |-> o_viol[iglc_pkg::V_SHAPE] && o_illegal)
    else $error("subgroup after unconditional-execute not flagged");
  mod_space_a: assert property (
    !$past(i_rst) && $past(i_grp_valid)
    |-> o_viol[iglc_pkg::V_MODCTL] == $past(sp.mod_ctl_hazard))
    else $error("modifier spacing verdict lost");
  mod_exempt_a: assert property (
    !sp.low_mod_use |=> !o_viol[iglc_pkg::V_MODCTL])
    else $error("exempt pointer use flagged");
  addr_space_a: assert property (
    !$past(i_rst) && $past(i_grp_valid)
    |-> o_viol[iglc_pkg::V_ASPACE] == $past(sp.addr_hazard))
    else $error("address spacing verdict lost");

  legal_group_c: cover property (o_chk_valid && !o_illegal);
  two_sg_c: cover property (i_grp_valid && n_sg == iglc_pkg::MAX_SUBGROUPS && !sg_over);
  sg_over_c: cover property (o_viol[iglc_pkg::V_SGLIM]);

endmodule
`default_nettype wire

// File: iglc_dispatch_model.sv
// dispatch stage model: presents one pre-decoded issue group per call
// assumes the caller steps it from a single process on the core clock
`timescale 1ns/1ps
`default_nettype none
module iglc_dispatch_model #(
  parameter int SLOTS = 6
) (
  // clock
  input wire logic i_ref_clk,
  // group towards the checker
  output var logic o_grp_valid,
  output var logic [SLOTS*iglc_pkg::SLOT_W-1:0] o_grp_slots
);
  initial begin
    o_grp_valid = 1'b0;
    o_grp_slots = '0;
  end

  // a group stands from this edge until the next call replaces it; valid is not dropped here
  task automatic issue(input logic [SLOTS*iglc_pkg::SLOT_W-1:0] v);
    @(posedge i_ref_clk);
    o_grp_valid <= 1'b1;
    o_grp_slots <= v;
  endtask

  // idle cycle: slots inverted each call, so a stale group returns on every second idle cycle and only o_grp_valid low keeps it from looking valid
  task automatic idle();
    @(posedge i_ref_clk);
    o_grp_valid <= 1'b0;
    o_grp_slots <= ~o_grp_slots;
  endtask
endmodule
`default_nettype wire

// File: iglc_checker_tb.sv
// self-checking bench for the issue group legality checker
// assumes the dispatch model owns the group inputs and verdicts come one cycle later
`timescale 1ns/1ps
`default_nettype none
module iglc_checker_tb;
  localparam int NS = 6;
  localparam int SW = iglc_pkg::SLOT_W;
  localparam int NV = iglc_pkg::NUM_VIOL;
  localparam logic [1:0] N = iglc_pkg::SG_NONE;
  localparam logic [1:0] A = iglc_pkg::SG_COND_A;
  localparam logic [1:0] B = iglc_pkg::SG_COND_B;
  localparam logic [1:0] U = iglc_pkg::SG_ALWAYS;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic grp_valid;
  logic [NS*SW-1:0] grp_slots;
  logic o_chk_valid;
  logic o_illegal;
  logic [NV-1:0] o_viol;
  logic [NV-1:0] exp_q[$];
  logic [NV-1:0] e_now;
  iglc_pkg::iglc_slot_type g[$];
  logic mon_on = 1'b0;
  int errors = 0;
  int check_count = 0;
  int id;
  int r;
  int nu;

  always #12.5 i_ref_clk = ~i_ref_clk;

  iglc_dispatch_model #(.SLOTS(NS)) i_disp (
    .i_ref_clk(i_ref_clk),
    .o_grp_valid(grp_valid),
    .o_grp_slots(grp_slots)
  );

  iglc_checker #(.SLOTS(NS)) i_dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_grp_valid(grp_valid),
    .i_grp_slots(grp_slots),
    .o_chk_valid(o_chk_valid),
    .o_illegal(o_illegal),
    .o_viol(o_viol)
  );

  function automatic logic [NV-1:0] vb(input int b);
    vb = '0;
    vb[b] = 1'b1;
  endfunction

  function automatic iglc_pkg::iglc_slot_type mk(input logic [1:0] sg, input string k,
                                                 input int v);
    iglc_pkg::iglc_slot_type s;
    s = '0;
    s.valid = 1'b1;
    s.sg = sg;
    case (k)
      "ext": s.ext = v[1:0];
      "cls": s.cls[v] = 1'b1;
      "sww": s.sww = 1'b1;
      "xret": s.xret = 1'b1;
      "agu": s.address_unit = 1'b1;
      "impl": s.agu_impl = 1'b1;
      "dreg": {s.address_unit, s.agu_dreg} = 2'h3;
      "data_arith_unit": s.data_arith_unit = 1'b1;
      "nop": s.is_prefix = 1'b1;
      "pfx": {s.is_prefix, s.cond_prefix} = 2'h3;
      "acc": {s.is_prefix, s.acc} = 2'h3;
      "accalu": {s.is_prefix, s.acc, s.acc_alu} = 3'h7;
      "nm": {s.nm_src_v, s.nm_src} = {1'b1, v[4:0]};
      "awr": {s.address_unit, s.awr_v, s.awr} = {2'h3, v[4:0]};
      "mrd": {s.mrd_v, s.mrd} = {1'b1, v[4:0]};
      "lpw": {s.lpc_wr_v, s.lpc_wr} = {1'b1, v[1:0]};
      "lpr": {s.lpc_rd_v, s.lpc_rd} = {1'b1, v[1:0]};
      "emr": s.emr_rd = 1'b1;
      "stk": {s.address_unit, s.stk_ret} = 2'h3;
      "mcw": s.mod_ctl_wr = 1'b1;
      "ptr": {s.address_unit, s.ptr_v, s.ptr_noupd, s.ptr} = {3'h6, v[3:0]};
      "ptrnu": {s.address_unit, s.ptr_v, s.ptr_noupd, s.ptr} = {3'h7, v[3:0]};
      "mwr": {s.mwr_v, s.mwr} = {1'b1, v[4:0]};
      "ause": {s.ause_v, s.ause} = {1'b1, v[4:0]};
      default: s.valid = 1'b1;
    endcase
    return s;
  endfunction

  // packs the pending slots, notes the expected verdict, hands the group over
  task automatic send(input logic [NV-1:0] e);
    logic [NS*SW-1:0] v;
    v = '0;
    foreach (g[k]) v[k*SW +: SW] = g[k];
    exp_q.push_back(e);
    i_disp.issue(v);
    g.delete();
  endtask

  task automatic pair(input logic [1:0] sa, input string ka, input int va,
                      input logic [1:0] sb, input string kb, input int wb,
                      input logic [NV-1:0] e);
    g.push_back(mk(sa, ka, va));
    g.push_back(mk(sb, kb, wb));
    send(e);
  endtask

  task automatic idle(input int n);
    repeat (n) i_disp.idle();
  endtask

  task automatic do_reset();
    i_disp.idle();
    i_rst <= 1'b1;
    repeat (1) @(posedge i_ref_clk);
    i_rst <= 1'b0;
  endtask

  task automatic chk_viol(input logic [NV-1:0] got, input logic [NV-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected viol at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected flag at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0) errors++;
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // verdict watcher: oldest note against each verdict, zeros otherwise
  always @(negedge i_ref_clk) begin
    if (mon_on) begin
      if (o_chk_valid === 1'b0) begin
        chk_viol(o_viol, '0);
      end else if (exp_q.size() == 0 || o_chk_valid !== 1'b1) begin
        chk_bit(o_chk_valid, 1'b0);
      end else begin
        e_now = exp_q.pop_front();
        chk_viol(o_viol, e_now);
        chk_bit(o_illegal, |e_now);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(60667));
    do_reset();
    mon_on = 1'b1;
    pair(N, "ext", 2, N, "data_arith_unit", 0, '0);
    pair(N, "ext", 2, N, "ext", 1, vb(iglc_pkg::V_EXT));
    pair(N, "ext", 1, N, "ext", 1, '0);
    g.push_back(mk(N, "ext", 1));
    pair(N, "ext", 1, N, "ext", 1, vb(iglc_pkg::V_EXT));
    for (int c = 0; c < iglc_pkg::NUM_CLS; c++) begin
      pair(N, "cls", c, N, "cls", c, vb(iglc_pkg::V_EXCL));
      pair(A, "cls", c, B, "cls", c, '0);
    end
    pair(A, "sww", 0, B, "sww", 0, vb(iglc_pkg::V_SWW));
    pair(N, "xret", 0, N, "agu", 0, vb(iglc_pkg::V_XRET));
    pair(A, "xret", 0, B, "data_arith_unit", 0, vb(iglc_pkg::V_XRET));
    pair(A, "xret", 0, A, "data_arith_unit", 0, '0);
    pair(N, "nm", 16, N, "nm", 16, vb(iglc_pkg::V_NMSRC));
    pair(A, "nm", 17, B, "nm", 17, '0);
    pair(N, "nm", 18, N, "nm", 19, '0);
    g.push_back(mk(A, "agu", 0));
    pair(A, "agu", 0, B, "data_arith_unit", 0, vb(iglc_pkg::V_SGLIM));
    g.push_back(mk(A, "data_arith_unit", 0));
    g.push_back(mk(A, "data_arith_unit", 0));
    pair(A, "data_arith_unit", 0, B, "agu", 0, vb(iglc_pkg::V_SGLIM));
    g.push_back(mk(A, "pfx", 0));
    g.push_back(mk(A, "acc", 0));
    g.push_back(mk(A, "agu", 0));
    g.push_back(mk(A, "data_arith_unit", 0));
    pair(A, "data_arith_unit", 0, B, "agu", 0, '0);
    g.push_back(mk(A, "impl", 0));
    pair(A, "agu", 0, B, "data_arith_unit", 0, vb(iglc_pkg::V_SGLIM));
    g.push_back(mk(A, "data_arith_unit", 0));
    pair(B, "data_arith_unit", 0, U, "data_arith_unit", 0, vb(iglc_pkg::V_SHAPE));
    pair(B, "pfx", 0, A, "data_arith_unit", 0, vb(iglc_pkg::V_SHAPE));
    pair(U, "data_arith_unit", 0, A, "data_arith_unit", 0, vb(iglc_pkg::V_SHAPE));
    pair(A, "data_arith_unit", 0, U, "data_arith_unit", 0, '0);
    pair(N, "dreg", 0, N, "acc", 0, vb(iglc_pkg::V_ACC_D));
    pair(N, "impl", 0, N, "acc", 0, '0);
    pair(A, "accalu", 0, B, "accalu", 0, vb(iglc_pkg::V_ACC_SG));
    pair(A, "accalu", 0, A, "accalu", 0, '0);
    id = $urandom_range(19);
    pair(N, "awr", id, N, "mrd", id, vb(iglc_pkg::V_AWR_RD));
    pair(A, "awr", id, B, "mrd", id, '0);
    pair(N, "lpw", 2, N, "lpr", 2, vb(iglc_pkg::V_LPC));
    pair(N, "lpw", 1, N, "lpr", 3, '0);
    pair(A, "lpw", 0, B, "lpr", 0, '0);
    pair(N, "stk", 0, N, "emr", 0, vb(iglc_pkg::V_EMR));
    pair(A, "stk", 0, B, "emr", 0, '0);
    // gap of d idle cycles between a writing group and a using group
    for (int d = 0; d < 3; d++) begin
      id = $urandom_range(19);
      pair(N, "mcw", 0, N, "mwr", id, '0);
      idle(d);
      pair(N, "ptr", 1, N, "ause", id, (d < 2 ? vb(iglc_pkg::V_MODCTL) : '0) |
           (d < 1 ? vb(iglc_pkg::V_ASPACE) : '0));
      idle(2);
    end
    repeat (8) begin
      r = $urandom_range(15);
      nu = $urandom_range(1);
      g.push_back(mk(N, "mcw", 0));
      send('0);
      g.push_back(mk(N, nu == 1 ? "ptrnu" : "ptr", r));
      send((r < 8 && nu == 0) ? vb(iglc_pkg::V_MODCTL) : '0);
      idle(2);
    end
    // a reset in mid-run must forget a pending modifier-control write
    g.push_back(mk(N, "mcw", 0));
    send('0);
    // one reset edge only: without it the use would still sit inside the modifier gap
    i_disp.idle();
    i_rst <= 1'b1;
    g.push_back(mk(N, "ptr", 0));
    send('0);
    i_rst <= 1'b0;
    g.push_back(mk(N, "nop", 0));
    send('0);
    idle(3);
    finish_test();
  end
endmodule
`default_nettype wire
